/* File: verilog/acs_params.svh */
`ifndef ACS_PARAMS_SVH
`define ACS_PARAMS_SVH

// Register indices; byte address is four times the index
`define ACS_IDX_PIN_SEL 6'h05
`define ACS_IDX_CTL 6'h06
`define ACS_IDX_CAL 6'h07
`define ACS_IDX_RES_HI 6'h08
`define ACS_IDX_RES_LO 6'h09
`define ACS_IDX_EVENT 6'h0A

// Converter control fields
`define ACS_CTL_REF_SEL 7
`define ACS_CTL_RATE_HI 6
`define ACS_CTL_RATE_LO 5
`define ACS_CTL_RUN 4
`define ACS_CTL_PWR 3
`define ACS_CTL_CH_HI 2
`define ACS_CTL_CH_LO 0

// Offset calibration fields
`define ACS_CAL_EN 7
`define ACS_CAL_SIGN 6
`define ACS_CAL_MAG_HI 5
`define ACS_CAL_MAG_LO 3

// Event register fields
`define ACS_EVT_DONE 0
`define ACS_EVT_IRQ_EN 1
`define ACS_EVT_WAKE_EN 2
`define ACS_EVT_GIE 3

// Reset values
`define ACS_RST_BYTE 8'h00
`define ACS_RST_CAL 5'h00
`define ACS_RST_RESULT 10'h000

// Conversion clock divide limits (divide ratio minus one)
`define ACS_DIV4_LIM 4'h3
`define ACS_DIV1_LIM 4'h0
`define ACS_DIV16_LIM 4'hF
`define ACS_DIV2_LIM 4'h1

// Sampling length in converter clock periods
`define ACS_SAMPLE_TICKS 3'h4

// Bus responses
`define ACS_RESP_OKAY 2'h0
`define ACS_RESP_SLVERR 2'h2

`endif

/* File: verilog/acs_pkg.sv */
package acs_pkg;
   typedef enum logic [1:0] {
      ACS_IDLE = 2'b00,
      ACS_SAMPLE = 2'b01,
      ACS_CONVERT = 2'b10
   } acs_sar_state_t;

   typedef enum logic [1:0] {
      ACS_RATE_DIV4 = 2'b00,
      ACS_RATE_DIV1 = 2'b01,
      ACS_RATE_DIV16 = 2'b10,
      ACS_RATE_DIV2 = 2'b11
   } acs_rate_t;
endpackage

/* File: verilog/acs_sar.sv */
`include "acs_params.svh"

module acs_sar #(
   parameter int RES_W = 10
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic ce_in,
   input wire logic start_in,
   input wire logic tick_in,
   input wire logic comp_in,
   output acs_pkg::acs_sar_state_t state_out,
   output logic busy_out,
   output logic done_out,
   output logic sample_out,
   output logic [RES_W-1:0] dac_code_out,
   output logic [RES_W-1:0] result_out
);
   import acs_pkg::*;

   acs_sar_state_t state_q, state_d;
   logic [2:0] samp_q, samp_d;
   logic [RES_W-1:0] code_q, code_d;
   logic [RES_W-1:0] trial_q, trial_d;
   logic done_d;

   // Keep or drop the trial bit, then move to the next lower one
   wire [RES_W-1:0] kept = comp_in ? code_q : (code_q & ~trial_q);
   wire [RES_W-1:0] top_bit = {1'b1, {(RES_W-1){1'b0}}};
   wire last_bit = trial_q[0];

   // Sample, then one decision per converter clock from the top bit
   always_comb begin
      state_d = state_q;
      samp_d = samp_q;
      code_d = code_q;
      trial_d = trial_q;
      done_d = 1'b0;
      unique case (state_q)
         ACS_IDLE: begin
            if (start_in) begin
               state_d = ACS_SAMPLE;
               samp_d = 3'h0;
            end
         end
         ACS_SAMPLE: begin
            if (tick_in) begin
               samp_d = samp_q + 3'h1;
               if (samp_q == `ACS_SAMPLE_TICKS - 3'h1) begin
                  state_d = ACS_CONVERT;
                  code_d = top_bit;
                  trial_d = top_bit;
               end
            end
         end
         ACS_CONVERT: begin
            if (tick_in) begin
               trial_d = trial_q >> 1;
               code_d = kept | (trial_q >> 1);
               if (last_bit) begin
                  code_d = kept;
                  state_d = ACS_IDLE;
                  done_d = 1'b1;
               end
            end
         end
         default: state_d = ACS_IDLE;
      endcase
   end

   // State and outputs, all frozen while the clock enable is low
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         state_q <= ACS_IDLE;
         samp_q <= 3'h0;
         code_q <= '0;
         trial_q <= '0;
         done_out <= 1'b0;
         result_out <= '0;
      end else if (ce_in) begin
         state_q <= state_d;
         samp_q <= samp_d;
         code_q <= code_d;
         trial_q <= trial_d;
         done_out <= done_d;
         if (done_d) begin
            result_out <= code_d;
         end
      end
   end

   assign state_out = state_q;
   assign busy_out = (state_q != ACS_IDLE);
   assign sample_out = (state_q == ACS_SAMPLE);
   assign dac_code_out = code_q;
endmodule

/* File: verilog/acs_top.sv */
// Summary of operation
// - Each pin select bit set makes its pin analog; clear leaves digital I/O.
// - Shared pin zero: interrupt function first, analog next, digital I/O last.
// - Reference select 0 uses supply and port pin; 1 uses reference pin.
// - Rate code 00 divides by 4, 01 by 1, 10 by 16, 11 by 2.
// - Writing 1 to run starts; only completion clears it; writing 0 ignored.
// - Power bit 0 switches the converter off; 1 makes the converter operate.
// - Three-bit channel field routes channel N, zero to seven, to the converter.
// - Offset correction applies only while calibration enable is 1.
// - Offset polarity 0 subtracts, 1 adds the correction.
// - Offset magnitude field gives the correction in LSBs, zero to seven.
// - Low three bits of offset calibration always read as zero.
// - Completion loads both result registers, clears run, sets done flag.
// - Ten-bit result by successive approximation, one bit per step, MSB first.
// - Each bit decision takes one converter clock period from the divider.
// - Completion in sleep wakes if enabled, otherwise converter shuts off.
//
// Our own choice: the AXI4-Lite slave port.
`include "acs_params.svh"

module acs_top #(
   parameter int RES_W = 10
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic ce_in,
   input wire logic [7:0] s_axi_awaddr_in,
   input wire logic s_axi_awvalid_in,
   output logic s_axi_awready_out,
   input wire logic [31:0] s_axi_wdata_in,
   input wire logic [3:0] s_axi_wstrb_in,
   input wire logic s_axi_wvalid_in,
   output logic s_axi_wready_out,
   output logic [1:0] s_axi_bresp_out,
   output logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   input wire logic [7:0] s_axi_araddr_in,
   input wire logic s_axi_arvalid_in,
   output logic s_axi_arready_out,
   output logic [31:0] s_axi_rdata_out,
   output logic [1:0] s_axi_rresp_out,
   output logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in,
   input wire logic comp_in,
   input wire logic ext_int_enable_in,
   input wire logic sleep_in,
   output logic [7:0] pin_analog_enable_out,
   output logic pin0_interrupt_out,
   output logic pin0_analog_out,
   output logic pin0_digital_out,
   output logic reference_source_select_out,
   output logic ref_pin_is_port_out,
   output logic converter_power_on_out,
   output logic [2:0] channel_select_out,
   output logic sample_out,
   output logic [RES_W-1:0] dac_code_out,
   output logic conversion_irq_out,
   output logic conversion_wake_out
);
   import acs_pkg::*;

   // Divide limit for each conversion clock rate code
   function automatic logic [3:0] div_limit(input logic [1:0] code);
      logic [3:0] lim;
      unique case (code)
         ACS_RATE_DIV4: lim = `ACS_DIV4_LIM;
         ACS_RATE_DIV1: lim = `ACS_DIV1_LIM;
         ACS_RATE_DIV16: lim = `ACS_DIV16_LIM;
         ACS_RATE_DIV2: lim = `ACS_DIV2_LIM;
      endcase
      return lim;
   endfunction

   // Signed offset correction with saturation at both ends of the range
   function automatic logic [RES_W-1:0] apply_offset(
      input logic [RES_W-1:0] raw, input logic en, input logic pos,
      input logic [2:0] mag);
      logic [RES_W:0] sum;
      logic [RES_W-1:0] res;
      sum = '0;
      res = raw;
      if (en) begin
         if (pos) begin
            sum = {1'b0, raw} + {{(RES_W-2){1'b0}}, mag};
            res = sum[RES_W] ? '1 : sum[RES_W-1:0];
         end else begin
            sum = {1'b0, raw} - {{(RES_W-2){1'b0}}, mag};
            res = sum[RES_W] ? '0 : sum[RES_W-1:0];
         end
      end
      return res;
   endfunction

   // Bus holding registers
   logic aw_rdy_q, w_rdy_q, aw_full_q, w_full_q, w_lane_q;
   logic bvalid_q, ar_rdy_q, rvalid_q;
   logic [7:0] aw_addr_q, w_data_q;
   logic [1:0] bresp_q, rresp_q;
   logic [31:0] rdata_q;

   // Software registers, converter clock divider and sleep state
   logic [7:0] pin_sel_q;
   logic ref_sel_q, pwr_q, run_q, run_d, done_flag_q, done_flag_d;
   logic irq_en_q, wake_en_q, gie_q, tick_q, shutdown_q;
   logic [1:0] rate_q;
   logic [2:0] chan_q;
   logic [3:0] div_cnt_q;
   logic [4:0] cal_q;
   logic [RES_W-1:0] result_q;

   // Registered pin outputs
   logic [7:0] pin_en_q;
   logic [2:0] chan_out_q;
   logic p0_int_q, p0_ana_q, p0_dig_q, ref_out_q, ref_port_q, pwr_out_q;
   logic irq_q, wake_q;

   // Converter engine
   logic sar_busy, sar_done, start_go;
   logic [RES_W-1:0] sar_result;

   acs_sar #(
      .RES_W(RES_W)
   ) u_sar (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .ce_in(ce_in),
      .start_in(start_go),
      .tick_in(tick_q),
      .comp_in(comp_in),
      .state_out(),
      .busy_out(sar_busy),
      .done_out(sar_done),
      .sample_out(sample_out),
      .dac_code_out(dac_code_out),
      .result_out(sar_result)
   );

   // Write decode
   wire [5:0] aw_idx = aw_addr_q[7:2];
   wire wr_go = aw_full_q & w_full_q & ~bvalid_q;
   wire wr_ok = wr_go & w_lane_q;
   wire wr_pin = wr_ok & (aw_idx == `ACS_IDX_PIN_SEL);
   wire wr_ctl = wr_ok & (aw_idx == `ACS_IDX_CTL);
   wire wr_cal = wr_ok & (aw_idx == `ACS_IDX_CAL);
   wire wr_evt = wr_ok & (aw_idx == `ACS_IDX_EVENT);
   wire aw_mapped = (aw_idx >= `ACS_IDX_PIN_SEL) &&
      (aw_idx <= `ACS_IDX_EVENT);

   // Start takes a written 1; written 0 leaves the run bit alone
   wire start_req = wr_ctl & w_data_q[`ACS_CTL_RUN];
   assign start_go = start_req & (~sar_busy | sar_done);

   // Read decode and data selection
   wire [5:0] ar_idx = s_axi_araddr_in[7:2];
   wire ar_take = s_axi_arvalid_in & ar_rdy_q;
   wire ar_mapped = (ar_idx >= `ACS_IDX_PIN_SEL) &&
      (ar_idx <= `ACS_IDX_EVENT);
   wire [7:0] ctl_val = {ref_sel_q, rate_q, run_q, pwr_q, chan_q};
   wire [7:0] cal_val = {cal_q, 3'b000};
   wire [7:0] evt_val = {4'h0, gie_q, wake_en_q, irq_en_q, done_flag_q};
   wire [7:0] rd_val =
      (ar_idx == `ACS_IDX_PIN_SEL) ? pin_sel_q :
      (ar_idx == `ACS_IDX_CTL) ? ctl_val :
      (ar_idx == `ACS_IDX_CAL) ? cal_val :
      (ar_idx == `ACS_IDX_RES_HI) ? result_q[RES_W-1:RES_W-8] :
      (ar_idx == `ACS_IDX_RES_LO) ? {6'h00, result_q[1:0]} :
      (ar_idx == `ACS_IDX_EVENT) ? evt_val : `ACS_RST_BYTE;

   // Corrected result from the engine
   wire [RES_W-1:0] corrected = apply_offset(sar_result,
      cal_q[4], cal_q[3], cal_q[2:0]);

   // Run and done flag next values; a set beats a same-cycle clear
   always_comb begin
      run_d = run_q;
      if (sar_done) begin
         run_d = 1'b0;
      end
      if (start_go) begin
         run_d = 1'b1;
      end
      done_flag_d = done_flag_q;
      if (wr_evt && w_data_q[`ACS_EVT_DONE]) begin
         done_flag_d = 1'b0;
      end
      if (sar_done) begin
         done_flag_d = 1'b1;
      end
   end

   // Write address and data channels, taken in either order
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         aw_rdy_q <= 1'b1;
         w_rdy_q <= 1'b1;
         aw_full_q <= 1'b0;
         w_full_q <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q <= 8'h00;
         w_lane_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= `ACS_RESP_OKAY;
      end else if (ce_in) begin
         if (s_axi_awvalid_in && aw_rdy_q) begin
            aw_addr_q <= s_axi_awaddr_in;
            aw_full_q <= 1'b1;
            aw_rdy_q <= 1'b0;
         end
         if (s_axi_wvalid_in && w_rdy_q) begin
            w_data_q <= s_axi_wdata_in[7:0];
            w_lane_q <= s_axi_wstrb_in[0];
            w_full_q <= 1'b1;
            w_rdy_q <= 1'b0;
         end
         if (wr_go) begin
            bvalid_q <= 1'b1;
            bresp_q <= aw_mapped ? `ACS_RESP_OKAY : `ACS_RESP_SLVERR;
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
         end
         if (bvalid_q && s_axi_bready_in) begin
            bvalid_q <= 1'b0;
            aw_rdy_q <= 1'b1;
            w_rdy_q <= 1'b1;
         end
      end
   end

   // Read channel, one read in flight
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         ar_rdy_q <= 1'b1;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= `ACS_RESP_OKAY;
      end else if (ce_in) begin
         if (ar_take) begin
            ar_rdy_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= {24'h00_0000, rd_val};
            rresp_q <= ar_mapped ? `ACS_RESP_OKAY : `ACS_RESP_SLVERR;
         end else if (rvalid_q && s_axi_rready_in) begin
            rvalid_q <= 1'b0;
            ar_rdy_q <= 1'b1;
         end
      end
   end

   // Configuration registers
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         pin_sel_q <= `ACS_RST_BYTE;
         ref_sel_q <= 1'b0;
         rate_q <= 2'b00;
         pwr_q <= 1'b0;
         chan_q <= 3'b000;
         cal_q <= `ACS_RST_CAL;
         irq_en_q <= 1'b0;
         wake_en_q <= 1'b0;
         gie_q <= 1'b0;
      end else if (ce_in) begin
         if (wr_pin) begin
            pin_sel_q <= w_data_q;
         end
         if (wr_ctl) begin
            ref_sel_q <= w_data_q[`ACS_CTL_REF_SEL];
            rate_q <= w_data_q[`ACS_CTL_RATE_HI:`ACS_CTL_RATE_LO];
            pwr_q <= w_data_q[`ACS_CTL_PWR];
            chan_q <= w_data_q[`ACS_CTL_CH_HI:`ACS_CTL_CH_LO];
         end
         if (wr_cal) begin
            cal_q <= w_data_q[`ACS_CAL_EN:`ACS_CAL_MAG_LO];
         end
         if (wr_evt) begin
            irq_en_q <= w_data_q[`ACS_EVT_IRQ_EN];
            wake_en_q <= w_data_q[`ACS_EVT_WAKE_EN];
            gie_q <= w_data_q[`ACS_EVT_GIE];
         end
      end
   end

   // Run bit, done flag and result registers
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         run_q <= 1'b0;
         done_flag_q <= 1'b0;
         result_q <= `ACS_RST_RESULT;
      end else if (ce_in) begin
         run_q <= run_d;
         done_flag_q <= done_flag_d;
         if (sar_done) begin
            result_q <= corrected;
         end
      end
   end

   // Converter clock: one tick per bit period at the selected rate
   wire div_hit = (div_cnt_q == div_limit(rate_q));
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         div_cnt_q <= 4'h0;
         tick_q <= 1'b0;
      end else if (ce_in) begin
         tick_q <= sar_busy & div_hit;
         div_cnt_q <= (sar_busy & ~div_hit) ? div_cnt_q + 4'h1 : 4'h0;
      end
   end

   // Sleep handling: wake on completion, or shut the converter off
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         shutdown_q <= 1'b0;
         wake_q <= 1'b0;
      end else if (ce_in) begin
         wake_q <= sar_done & sleep_in & wake_en_q;
         shutdown_q <= sleep_in & (shutdown_q | (sar_done & ~wake_en_q));
      end
   end

   // Pin function and converter steering outputs
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         pin_en_q <= 8'h00;
         p0_int_q <= 1'b0;
         p0_ana_q <= 1'b0;
         p0_dig_q <= 1'b1;
         ref_out_q <= 1'b0;
         ref_port_q <= 1'b1;
         pwr_out_q <= 1'b0;
         chan_out_q <= 3'b000;
         irq_q <= 1'b0;
      end else if (ce_in) begin
         pin_en_q <= pin_sel_q;
         p0_int_q <= ext_int_enable_in;
         p0_ana_q <= ~ext_int_enable_in & pin_sel_q[0];
         p0_dig_q <= ~ext_int_enable_in & ~pin_sel_q[0];
         ref_out_q <= ref_sel_q;
         ref_port_q <= ~ref_sel_q;
         pwr_out_q <= pwr_q & ~shutdown_q;
         chan_out_q <= chan_q;
         irq_q <= done_flag_q & irq_en_q & gie_q;
      end
   end

   assign s_axi_awready_out = aw_rdy_q;
   assign s_axi_wready_out = w_rdy_q;
   assign s_axi_bvalid_out = bvalid_q;
   assign s_axi_bresp_out = bresp_q;
   assign s_axi_arready_out = ar_rdy_q;
   assign s_axi_rvalid_out = rvalid_q;
   assign s_axi_rdata_out = rdata_q;
   assign s_axi_rresp_out = rresp_q;
   assign pin_analog_enable_out = pin_en_q;
   assign pin0_interrupt_out = p0_int_q;
   assign pin0_analog_out = p0_ana_q;
   assign pin0_digital_out = p0_dig_q;
   assign reference_source_select_out = ref_out_q;
   assign ref_pin_is_port_out = ref_port_q;
   assign converter_power_on_out = pwr_out_q;
   assign channel_select_out = chan_out_q;
   assign conversion_irq_out = irq_q;
   assign conversion_wake_out = wake_q;
endmodule

/* File: verification/acs_core_model.sv */
// Converter core: analog mux plus comparator against the trial code
module acs_core_model (
   input wire logic [2:0] channel_in,
   input wire logic [9:0] code_in,
   output logic comp_out
);
   timeunit 1ns;
   timeprecision 1ps;
   int level;

   // Each channel carries its own fixed level
   assign level = int'(channel_in) * 140 + 9;
   // Keep the trial bit while the input is at or above the code
   assign comp_out = (level >= int'(code_in));
endmodule

/* File: verification/acs_chk_sva.sv */
module acs_chk_sva (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic s_axi_awvalid_in,
   input wire logic s_axi_awready_out,
   input wire logic s_axi_wvalid_in,
   input wire logic s_axi_wready_out,
   input wire logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   input wire logic s_axi_arvalid_in,
   input wire logic s_axi_arready_out,
   input wire logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in,
   input wire logic [31:0] s_axi_rdata_out,
   input wire logic [7:0] pin_analog_enable_out,
   input wire logic pin0_interrupt_out,
   input wire logic pin0_analog_out,
   input wire logic pin0_digital_out,
   input wire logic reference_source_select_out,
   input wire logic ref_pin_is_port_out,
   input wire logic [2:0] channel_select_out,
   input wire logic sample_out,
   input wire logic sleep_in,
   input wire logic conversion_wake_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // One clock domain; reset quiets every check
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (rst_in);

   chk_write_answer: assert property (s_axi_awvalid_in && s_axi_awready_out
      && s_axi_wvalid_in && s_axi_wready_out |-> ##2 s_axi_bvalid_out)
      else $error("write response late");
   chk_bresp_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in
      |=> s_axi_bvalid_out) else $error("write response dropped");
   chk_read_answer: assert property (s_axi_arvalid_in && s_axi_arready_out
      |=> s_axi_rvalid_out) else $error("read response late");
   chk_rdata_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in
      |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
      else $error("read data not held");
   chk_pin0_onehot: assert property (
      $onehot({pin0_interrupt_out, pin0_analog_out, pin0_digital_out}))
      else $error("pin zero function not unique");
   chk_ref_pin_port: assert property (
      ref_pin_is_port_out != reference_source_select_out)
      else $error("reference pin role wrong");
   chk_chan_by_write: assert property (
      $changed(channel_select_out) |-> $past(s_axi_bvalid_out))
      else $error("channel moved without write");
   chk_pins_by_write: assert property (
      $changed(pin_analog_enable_out) |-> $past(s_axi_bvalid_out))
      else $error("pin enables moved without write");
   chk_sample_len: assert property (
      $rose(sample_out) |-> sample_out [*4])
      else $error("sampling too short");
   chk_wake_pulse: assert property (
      conversion_wake_out |=> !conversion_wake_out)
      else $error("wake longer than one cycle");
   chk_wake_asleep: assert property (
      conversion_wake_out |-> $past(sleep_in))
      else $error("wake while awake");
endmodule

/* File: verification/tb_top.sv */
`include "acs_params.svh"
`define CK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
   err_count++; $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); \
   end end

module tb_top;
   import acs_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {
      logic [5:0] ix;
      logic [7:0] w;
      logic [7:0] r;
      logic [1:0] s;
   } acs_row_t;
   logic clk_in, rst_in, ce_in, comp_in, ext_int_enable_in, sleep_in, slow;
   logic s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in;
   logic s_axi_arvalid_in, s_axi_rready_in;
   logic [7:0] s_axi_awaddr_in, s_axi_araddr_in, pin_analog_enable_out;
   logic [31:0] s_axi_wdata_in, s_axi_rdata_out, rdv;
   logic [3:0] s_axi_wstrb_in;
   logic [1:0] s_axi_bresp_out, s_axi_rresp_out, rs;
   logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
   logic s_axi_arready_out, s_axi_rvalid_out, pin0_interrupt_out;
   logic pin0_analog_out, pin0_digital_out, reference_source_select_out;
   logic ref_pin_is_port_out, converter_power_on_out, sample_out;
   logic conversion_irq_out, conversion_wake_out;
   logic [2:0] channel_select_out;
   logic [9:0] dac_code_out;
   int err_count, n_checks, wakes;
   acs_row_t rows [7] = '{
      '{`ACS_IDX_PIN_SEL, 8'hA5, 8'hA5, `ACS_RESP_OKAY},
      '{`ACS_IDX_CAL, 8'hFF, 8'hF8, `ACS_RESP_OKAY},
      '{`ACS_IDX_CTL, 8'hE7, 8'hE7, `ACS_RESP_OKAY},
      '{`ACS_IDX_EVENT, 8'h0E, 8'h0E, `ACS_RESP_OKAY},
      '{`ACS_IDX_RES_HI, 8'hFF, 8'h00, `ACS_RESP_OKAY},
      '{`ACS_IDX_RES_LO, 8'hFF, 8'h00, `ACS_RESP_OKAY},
      '{6'h0B, 8'h55, 8'h00, `ACS_RESP_SLVERR}};

   acs_top dut (.*);
   acs_core_model core (.channel_in(channel_select_out),
      .code_in(dac_code_out), .comp_out(comp_in));

   // Clock and hang guard
   initial begin
      clk_in = 1'b0;
      forever #20 clk_in = ~clk_in;
   end
   initial begin
      repeat (30000) @(posedge clk_in);
      err_count++;
      wrap_up();
   end
   always @(posedge clk_in) begin
      if (conversion_wake_out === 1'b1) wakes++;
   end

   task automatic wrap_up();
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Bus write; a slow master holds off bready for a few cycles
   task automatic wr(input logic [5:0] ix, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk_in);
      s_axi_awaddr_in <= {ix, 2'b00};
      s_axi_wdata_in <= {24'h00_0000, d};
      s_axi_awvalid_in <= 1'b1;
      s_axi_wvalid_in <= 1'b1;
      s_axi_bready_in <= !slow;
      do begin
         @(posedge clk_in);
         n++;
         if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
         if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
         if (n == 3 && !s_axi_bready_in) s_axi_bready_in <= 1'b1;
      end while (!(s_axi_bvalid_out && s_axi_bready_in) && n < 60);
      rs = s_axi_bresp_out;
      s_axi_bready_in <= 1'b0;
      if (n >= 60) begin
         err_count++;
         wrap_up();
      end
   endtask

   // Bus read into rdv and rs
   task automatic rd(input logic [5:0] ix);
      int n;
      n = 0;
      @(posedge clk_in);
      s_axi_araddr_in <= {ix, 2'b00};
      s_axi_arvalid_in <= 1'b1;
      s_axi_rready_in <= !slow;
      do begin
         @(posedge clk_in);
         n++;
         if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
         if (n == 3 && !s_axi_rready_in) s_axi_rready_in <= 1'b1;
      end while (!(s_axi_rvalid_out && s_axi_rready_in) && n < 60);
      rdv = s_axi_rdata_out;
      rs = s_axi_rresp_out;
      s_axi_rready_in <= 1'b0;
      if (n >= 60) begin
         err_count++;
         wrap_up();
      end
   endtask

   // One conversion: time a decision, then check run, result and flag
   task automatic conv(input acs_rate_t r, input logic [2:0] ch,
      input logic [7:0] cal, input logic [7:0] evt);
      int dv, t, ex;
      logic [9:0] c0;
      dv = r == ACS_RATE_DIV4 ? 4 : r == ACS_RATE_DIV1 ? 1 :
         r == ACS_RATE_DIV16 ? 16 : 2;
      ex = int'(ch) * 140 + 9;
      if (cal[7]) ex = cal[6] ? ex + int'(cal[5:3]) : ex - int'(cal[5:3]);
      wr(`ACS_IDX_CAL, cal);
      wr(`ACS_IDX_EVENT, evt);
      wr(`ACS_IDX_CTL, {1'b0, r, 1'b0, 1'b1, ch});
      repeat (50) @(posedge clk_in);
      wr(`ACS_IDX_CTL, {1'b0, r, 1'b1, 1'b1, ch});
      t = 0;
      while (sample_out !== 1'b0 && t < 100) begin
         @(posedge clk_in);
         t++;
      end
      for (int k = 0; k < 2; k++) begin
         c0 = dac_code_out;
         t = 0;
         while (dac_code_out === c0 && t < 40) begin
            @(posedge clk_in);
            t++;
         end
      end
      `CK("decision time", dv, t)
      if (r == ACS_RATE_DIV16) begin
         wr(`ACS_IDX_CTL, {1'b0, r, 1'b0, 1'b1, ch});
         rd(`ACS_IDX_CTL);
         `CK("run kept", 1'b1, rdv[`ACS_CTL_RUN])
      end
      t = 0;
      do begin
         rd(`ACS_IDX_CTL);
         t++;
      end while (rdv[`ACS_CTL_RUN] === 1'b1 && t < 100);
      `CK("run cleared", 1'b0, rdv[`ACS_CTL_RUN])
      rd(`ACS_IDX_RES_HI);
      `CK("result high", ex[9:2], rdv[7:0])
      rd(`ACS_IDX_RES_LO);
      `CK("result low", {6'h00, ex[1:0]}, rdv[7:0])
      rd(`ACS_IDX_EVENT);
      `CK("done flag", 1'b1, rdv[`ACS_EVT_DONE])
      `CK("irq", evt[1] & evt[3], conversion_irq_out)
      repeat (2 * dv) @(posedge clk_in);
   endtask

   initial begin
      rst_in = 1'b1;
      ce_in = 1'b1;
      slow = 1'b0;
      wakes = 0;
      err_count = 0;
      n_checks = 0;
      {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} = 3'h0;
      {s_axi_arvalid_in, s_axi_rready_in} = 2'h0;
      {s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in} = 48'h0000_0000_0000;
      s_axi_wstrb_in = 4'hF;
      ext_int_enable_in = 1'b0;
      sleep_in = 1'b0;
      repeat (4) @(posedge clk_in);
      rst_in <= 1'b0;
      // Register write, read-back, read-only and unmapped places
      foreach (rows[i]) begin
         slow = i[0];
         wr(rows[i].ix, rows[i].w);
         `CK("write resp", rows[i].s, rs)
         rd(rows[i].ix);
         `CK("read resp", rows[i].s, rs)
         `CK("read data", {24'h00_0000, rows[i].r}, rdv)
      end
      // Pin roles and converter routing
      wr(`ACS_IDX_CTL, 8'h8F);
      repeat (2) @(posedge clk_in);
      `CK("pin enables", 8'hA5, pin_analog_enable_out)
      `CK("channel", 3'h7, channel_select_out)
      `CK("ext ref", 1'b1, reference_source_select_out)
      `CK("ref port", 1'b0, ref_pin_is_port_out)
      `CK("power", 1'b1, converter_power_on_out)
      `CK("pin0 analog", 1'b1, pin0_analog_out)
      ext_int_enable_in <= 1'b1;
      repeat (3) @(posedge clk_in);
      `CK("pin0 irq", 1'b1, pin0_interrupt_out)
      ext_int_enable_in <= 1'b0;
      wr(`ACS_IDX_CTL, 8'h00);
      wr(`ACS_IDX_PIN_SEL, 8'h00);
      repeat (2) @(posedge clk_in);
      `CK("power off", 1'b0, converter_power_on_out)
      `CK("port pin", 1'b1, ref_pin_is_port_out)
      `CK("pin0 digital", 1'b1, pin0_digital_out)
      // Every rate code, offset on, off, up and down
      conv(ACS_RATE_DIV4, 3'h3, 8'h00, 8'h0B);
      conv(ACS_RATE_DIV1, 3'h5, 8'hA8, 8'h0B);
      conv(ACS_RATE_DIV16, 3'h0, 8'hD8, 8'h0B);
      conv(ACS_RATE_DIV2, 3'h7, 8'h78, 8'h09);
      // Completion in sleep, with and without wake
      sleep_in <= 1'b1;
      conv(ACS_RATE_DIV1, 3'h2, 8'h00, 8'h05);
      `CK("wake pulses", 1, wakes)
      conv(ACS_RATE_DIV1, 3'h2, 8'h00, 8'h01);
      `CK("sleep power", 1'b0, converter_power_on_out)
      sleep_in <= 1'b0;
      repeat (3) @(posedge clk_in);
      `CK("awake power", 1'b1, converter_power_on_out)
      // Reset after the last conversion returns every register to zero
      rst_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      rst_in <= 1'b0;
      for (int ix = 5; ix <= 10; ix++) begin
         rd(6'(ix));
         `CK("reset value", 32'h0000_0000, rdv)
      end
      wrap_up();
   end
endmodule

bind acs_top acs_chk_sva chk (.clk_in, .rst_in, .s_axi_awvalid_in,
   .s_axi_awready_out, .s_axi_wvalid_in, .s_axi_wready_out,
   .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_arvalid_in,
   .s_axi_arready_out, .s_axi_rvalid_out, .s_axi_rready_in,
   .s_axi_rdata_out, .pin_analog_enable_out, .pin0_interrupt_out,
   .pin0_analog_out, .pin0_digital_out, .reference_source_select_out,
   .ref_pin_is_port_out, .channel_select_out, .sample_out, .sleep_in,
   .conversion_wake_out);
